//--- shared/watch_defs.vh
// Purpose: Constants for the watch comparator block
// Assumes: 32-bit APB, one word per register
// Notes:   Offsets and field positions are named here only
`ifndef WATCH_DEFS_VH
`define WATCH_DEFS_VH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define NUM_COMP        4
`define NUM_VALUE_COMP  2
`define IDX_W           2
`define ADDR_W          12

// ---------------------------------------------------------------
// Register map (per comparator stride, byte addresses)
// ---------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_CYCLE_COUNTER      12'h004
`define OFS_COMP_BASE   12'h020
`define COMP_STRIDE_SH  4
`define SUB_COMP        2'h0
`define SUB_MASK        2'h1
`define SUB_FUNC        2'h2

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTRL_CYCENA     0
`define CTRL_NOCYC      25

// ---------------------------------------------------------------
// Config register fields
// ---------------------------------------------------------------
`define F_ACT_LO        0
`define F_ACT_HI        3
`define F_CYC           7
`define F_VAL           8
`define F_LNK1          9
`define F_SIZE_LO       10
`define F_SIZE_HI       11
`define F_LA_LO         12
`define F_LA_HI         15
`define F_LB_LO         16
`define F_LB_HI         19
`define F_RANGE         5
`define F_WR_MASK       32'h000ffdaf

// ---------------------------------------------------------------
// Action codes
// ---------------------------------------------------------------
`define ACT_OFF         4'h0
`define ACT_TRACE_PC    4'h1
`define ACT_WP          4'h4
`define ACT_WP_RD       4'h5
`define ACT_WP_WR       4'h6
`define ACT_WP_RW       4'h7
`define ACT_MATCH       4'h8
`define ACT_MATCH_RD    4'h9
`define ACT_MATCH_WR    4'ha
`define ACT_MATCH_RW    4'hb

// ---------------------------------------------------------------
// Sizes of value compare and of access
// ---------------------------------------------------------------
`define VSZ_BYTE        2'h0
`define VSZ_HALF        2'h1
`define VSZ_WORD        2'h2
`define ASZ_BYTE        2'h0
`define ASZ_HALF        2'h1
`define ASZ_WORD        2'h2

`define MASK_W          5
`define ZERO32          32'h00000000
`define PSLVERR_UNMAP   1'b1

`endif

//--- rtl/watch_value_match.v
// Purpose: Inexact data value compare for one comparator
// Assumes: Little-endian data, compare value replicated by software
// Notes:   Pure combinational, one instance per comparator
`timescale 1ns/1ps
`include "watch_defs.vh"

module watch_value_match (
  input  wire [1:0]  value_size,
  input  wire [31:0] compare_value,
  input  wire [1:0]  acc_size,
  input  wire [31:0] acc_data,
  output reg         hit
);

  wire [7:0]  cb = compare_value[7:0];
  wire [15:0] ch = compare_value[15:0];

  // -------------------------------------------------------------
  // Lane compare
  // -------------------------------------------------------------
  always @* begin
    hit = 1'b0;
    case (value_size)
      `VSZ_BYTE: begin
        case (acc_size)
          `ASZ_BYTE: hit = (cb == acc_data[7:0]);
          `ASZ_HALF: hit = (cb == acc_data[7:0]) ||
                           (cb == acc_data[15:8]);
          `ASZ_WORD: hit = (cb == acc_data[7:0]) ||
                           (cb == acc_data[15:8]) ||
                           (cb == acc_data[23:16]) ||
                           (cb == acc_data[31:24]);
          default:   hit = 1'b0;
        endcase
      end
      `VSZ_HALF: begin
        case (acc_size)
          `ASZ_HALF: hit = (ch == acc_data[15:0]);
          `ASZ_WORD: hit = (ch == acc_data[15:0]) ||
                           (ch == acc_data[23:8]) ||
                           (ch == acc_data[31:16]);
          default:   hit = 1'b0;
        endcase
      end
      `VSZ_WORD: hit = (acc_size == `ASZ_WORD) &&
                       (compare_value == acc_data);
      // Size 11 result is unknown; never matching is the safe pick
      default:   hit = 1'b0;
    endcase
  end

endmodule // watch_value_match

//--- rtl/watch_cycle_value_compare.v
// Purpose: Cycle count and data value watch comparators behind APB
// Assumes: Access and commit strobes arrive from core logic on pclk
// Notes:   Address compare is done outside; its hits come in per unit
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "watch_defs.vh"

module watch_cycle_value_compare #(
  parameter CYC_PRESENT = 1
) (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`ADDR_W-1:0]    paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output wire                  pready,
  output wire                  pslverr,
  input  wire                  commit_valid,
  input  wire                  acc_valid,
  input  wire                  acc_write,
  input  wire [1:0]            acc_size,
  input  wire [31:0]           acc_data,
  input  wire [31:0]           acc_pc,
  input  wire [`NUM_COMP-1:0]  addr_hit,
  output wire [`NUM_COMP-1:0]  address_mask_nonzero,
  output reg                   watch_event,
  output reg                   trace_req,
  output reg  [31:0]           trace_pc,
  output reg  [`NUM_COMP-1:0]  comparator_match_out
);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  reg  [31:0]          compare_value [0:`NUM_COMP-1];
  reg  [`MASK_W-1:0]   address_mask [0:`NUM_COMP-1];
  reg  [31:0]          comparator_config [0:`NUM_COMP-1];
  reg                  cyc_enable;
  reg  [31:0]          cycle_counter;

  wire cycle_counter_absent = (CYC_PRESENT == 0);

  // -------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------
  wire        acc_cyc  = psel & penable;
  wire        is_ctrl  = (paddr == `OFS_CTRL);
  wire        is_cnt   = (paddr == `OFS_CYCLE_COUNTER);
  wire [11:0] rel      = paddr - `OFS_COMP_BASE;
  wire [1:0]  sub      = rel[3:2];
  wire [`IDX_W-1:0] cidx = rel[`COMP_STRIDE_SH+`IDX_W-1:`COMP_STRIDE_SH];
  wire        in_comp  = (paddr >= `OFS_COMP_BASE) &&
                         (rel[11:`COMP_STRIDE_SH+`IDX_W] == 6'h00) &&
                         (rel[1:0] == 2'h0) && (sub != 2'h3);
  wire        mapped   = is_ctrl | is_cnt | in_comp;

  assign pready  = 1'b1;
  assign pslverr = acc_cyc & ~mapped & `PSLVERR_UNMAP;

  function has_value;
    input [`IDX_W-1:0] i;
    begin
      has_value = (i < `NUM_VALUE_COMP);
    end
  endfunction

  // Writable config bits per comparator: hardwired bits dropped
  function [31:0] cfg_wr;
    input [`IDX_W-1:0] i;
    input [31:0]       d;
    begin
      cfg_wr = d & `F_WR_MASK;
      cfg_wr[`F_LNK1] = 1'b0;
      if (!has_value(i)) begin
        cfg_wr[`F_VAL] = 1'b0;
        cfg_wr[`F_LB_HI:`F_LB_LO] = 4'h0;
      end
      if ((i != 0) || cycle_counter_absent)
        cfg_wr[`F_CYC] = 1'b0;
    end
  endfunction

  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < `NUM_COMP; k = k + 1) begin
        compare_value[k]     <= `ZERO32;
        address_mask[k]      <= 5'h00;
        comparator_config[k] <= `ZERO32;
      end
      cyc_enable <= 1'b0;
    end else if (acc_cyc && pwrite && in_comp) begin
      case (sub)
        `SUB_COMP: compare_value[cidx] <= pwdata;
        `SUB_MASK: address_mask[cidx] <= pwdata[`MASK_W-1:0];
        `SUB_FUNC: comparator_config[cidx] <= cfg_wr(cidx, pwdata);
        default:   compare_value[cidx] <= compare_value[cidx];
      endcase
    end else if (acc_cyc && pwrite && is_ctrl) begin
      cyc_enable <= pwdata[`CTRL_CYCENA] & ~cycle_counter_absent;
    end
  end

  // Counter runs only when enabled; software may also load it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cycle_counter <= `ZERO32;
    else if (acc_cyc && pwrite && is_cnt)
      cycle_counter <= pwdata;
    else if (cyc_enable)
      cycle_counter <= cycle_counter + 32'h00000001;
  end

  // Link b present only on value comparators
  function [31:0] cfg_rd;
    input [`IDX_W-1:0] i;
    begin
      cfg_rd = comparator_config[i];
      cfg_rd[`F_LNK1] = has_value(i);
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= `ZERO32;
      if (is_ctrl) begin
        prdata[`CTRL_CYCENA] <= cyc_enable;
        prdata[`CTRL_NOCYC]  <= cycle_counter_absent;
      end else if (is_cnt) begin
        prdata <= cycle_counter;
      end else if (in_comp) begin
        case (sub)
          `SUB_COMP: prdata <= compare_value[cidx];
          `SUB_MASK: prdata <= {27'h0000000, address_mask[cidx]};
          `SUB_FUNC: prdata <= cfg_rd(cidx);
          default:   prdata <= `ZERO32;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Match logic
  // -------------------------------------------------------------
  wire [`NUM_COMP-1:0] vhit;
  reg  [`NUM_COMP-1:0] next_match;
  reg  [`NUM_COMP-1:0] next_wp;
  reg  [`NUM_COMP-1:0] next_tr;

  genvar g;
  generate
    for (g = 0; g < `NUM_COMP; g = g + 1) begin : gen_vm
      watch_value_match u_vm (
        .value_size    (comparator_config[g][`F_SIZE_HI:`F_SIZE_LO]),
        .compare_value (compare_value[g]),
        .acc_size      (acc_size),
        .acc_data      (acc_data),
        .hit           (vhit[g])
      );
      assign address_mask_nonzero[g] = |address_mask[g];
    end
  endgenerate

  reg [3:0]        act;
  reg [`IDX_W-1:0] la;
  reg [`IDX_W-1:0] lb;
  reg              do_a;
  reg              do_b;
  reg              hit;
  reg              rd_ok;
  reg              wr_ok;
  integer n;
  always @* begin
    next_match = {`NUM_COMP{1'b0}};
    next_wp    = {`NUM_COMP{1'b0}};
    next_tr    = {`NUM_COMP{1'b0}};
    act = 4'h0;
    la = {`IDX_W{1'b0}};
    lb = {`IDX_W{1'b0}};
    do_a = 1'b0;
    do_b = 1'b0;
    hit = 1'b0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    for (n = 0; n < `NUM_COMP; n = n + 1) begin
      act = comparator_config[n][`F_ACT_HI:`F_ACT_LO];
      if (n == 0 && !cycle_counter_absent &&
          comparator_config[n][`F_CYC] &&
          !comparator_config[n][`F_VAL]) begin
        if (commit_valid &&
            cycle_counter == compare_value[n]) begin
          case (act)
            `ACT_TRACE_PC: next_tr[n]    = 1'b1;
            `ACT_WP:       next_wp[n]    = 1'b1;
            `ACT_MATCH:    next_match[n] = 1'b1;
            default:       next_tr[n]    = 1'b0;
          endcase
        end
      end else if (has_value(n[`IDX_W-1:0]) &&
                   comparator_config[n][`F_VAL]) begin
        la = comparator_config[n][`F_LA_LO+`IDX_W-1:`F_LA_LO];
        lb = comparator_config[n][`F_LB_LO+`IDX_W-1:`F_LB_LO];
        // Second link exists exactly on the value comparators
        do_b = has_value(n[`IDX_W-1:0]) && (lb != n);
        do_a = (la != n);
        if (do_a || do_b)
          hit = ((do_a && addr_hit[la]) ||
                 (do_b && addr_hit[lb])) && vhit[n];
        else
          hit = vhit[n];
        rd_ok = acc_valid && !acc_write && hit;
        wr_ok = acc_valid && acc_write && hit;
        case (act)
          `ACT_WP_RD:    next_wp[n]    = rd_ok;
          `ACT_WP_WR:    next_wp[n]    = wr_ok;
          `ACT_WP_RW:    next_wp[n]    = rd_ok | wr_ok;
          `ACT_MATCH_RD: next_match[n] = rd_ok;
          `ACT_MATCH_WR: next_match[n] = wr_ok;
          `ACT_MATCH_RW: next_match[n] = rd_ok | wr_ok;
          default:       next_wp[n]    = 1'b0;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // Outputs: one pulse per matching access or commit
  // -------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_event          <= 1'b0;
      trace_req            <= 1'b0;
      trace_pc             <= `ZERO32;
      comparator_match_out <= {`NUM_COMP{1'b0}};
    end else begin
      watch_event          <= |next_wp;
      trace_req            <= |next_tr;
      comparator_match_out <= next_match;
      if (|next_tr)
        trace_pc <= acc_pc;
    end
  end

endmodule // watch_cycle_value_compare

//--- dv/watch_props.sv
// Purpose: Concurrent checks on the watch comparator outputs
// Assumes: Outputs are registered one cycle after the request edge
// Notes:   Bound into every instance of the block
`timescale 1ns/1ps
`include "watch_defs.vh"
module watch_props (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 commit_valid,
  input wire logic                 acc_valid,
  input wire logic [31:0]          acc_pc,
  input wire logic                 watch_event,
  input wire logic                 trace_req,
  input wire logic [31:0]          trace_pc,
  input wire logic [`NUM_COMP-1:0] comparator_match_out
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_event_cause:
    assert property (watch_event |-> $past(commit_valid || acc_valid))
    else $error("watch event with no request");
  a_trace_cause:
    assert property (trace_req |-> $past(commit_valid) &&
                     trace_pc == $past(acc_pc))
    else $error("trace request without commit or wrong pc");
  a_match_cause:
    assert property (|comparator_match_out |->
                     $past(commit_valid || acc_valid))
    else $error("match output with no request");
  a_upper_quiet:
    assert property (comparator_match_out[3:2] == 2'h0)
    else $error("match on comparator without value or cycle mode");
  a_single_pulse:
    assert property (watch_event ##1 watch_event |->
                     $past(commit_valid || acc_valid))
    else $error("watch event longer than its requests");
  a_trace_hold:
    assert property (!trace_req |-> $stable(trace_pc))
    else $error("trace pc moved without trace");
  a_slverr_phase:
    assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ready_access:
    assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule // watch_props

bind watch_cycle_value_compare watch_props watch_props_inst (.*);

//--- dv/core_model.sv
// Purpose: Core side stream of commits and data accesses
// Assumes: One pulse per request, driven just after a rising edge
// Notes:   Idle data, pc and hit lines show inverted last value; write and size lines keep a stale copy
`timescale 1ns/1ps
module core_model (
  input  wire logic        pclk,
  output logic             commit_valid,
  output logic             acc_valid,
  output logic             acc_write,
  output logic [1:0]       acc_size,
  output logic [31:0]      acc_data,
  output logic [31:0]      acc_pc,
  output logic [3:0]       addr_hit
);
  initial begin
    {commit_valid, acc_valid, acc_write, acc_size} = '0;
    {acc_data, acc_pc, addr_hit} = '0;
  end
  task automatic step(input logic c, a, w, input logic [1:0] s,
                      input logic [31:0] d, p, input logic [3:0] h);
    @(posedge pclk);
    commit_valid <= c;
    acc_valid    <= a;
    acc_write    <= w;
    acc_size     <= s;
    acc_data     <= d;
    acc_pc       <= p;
    addr_hit     <= h;
    @(posedge pclk);
    commit_valid <= 1'b0;
    acc_valid    <= 1'b0;
    acc_data     <= ~d;
    acc_pc       <= ~p;
    addr_hit     <= ~h;
  endtask
endmodule // core_model

//--- dv/testbench.sv
// Purpose: Self-checking bench for the watch comparator block
// Assumes: APB master waits for ready, never counts on wait states
// Notes:   Counter is stopped in cycle tests so matches are exact
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic        pready, pslverr, commit_valid, acc_valid, acc_write;
  logic        watch_event, trace_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_data, acc_pc, trace_pc, r;
  logic [1:0]  acc_size;
  logic [3:0]  addr_hit, mask_nz, cmo;
  int          bad_count = 0;
  int          tests_run = 0;
  typedef struct {
    logic [31:0] cfg, cmp;
    logic        w;
    logic [1:0]  s;
    logic [31:0] d;
    logic [5:0]  o;
  } row_t;
  row_t rows[14] = '{
    '{32'h105, 32'h5a5a5a5a, 0, 2, 32'h11225a33, 6'h20},
    '{32'h105, 32'h5a5a5a5a, 1, 2, 32'h11225a33, 6'h00},
    '{32'h106, 32'h5a5a5a5a, 1, 0, 32'h0000005a, 6'h20},
    '{32'h507, 32'h12341234, 1, 2, 32'hff123400, 6'h20},
    '{32'h507, 32'h12341234, 0, 0, 32'h00000034, 6'h00},
    '{32'h507, 32'h12341234, 0, 1, 32'h00001234, 6'h20},
    '{32'h90b, 32'hdeadbeef, 0, 2, 32'hdeadbeef, 6'h01},
    '{32'h90b, 32'hdeadbeef, 1, 1, 32'h0000beef, 6'h00},
    '{32'hd0b, 32'hdeadbeef, 1, 2, 32'hdeadbeef, 6'h00},
    '{32'h109, 32'h5a5a5a5a, 0, 1, 32'h00005a00, 6'h01},
    '{32'h109, 32'h5a5a5a5a, 1, 1, 32'h00005a00, 6'h00},
    '{32'h90a, 32'hdeadbeef, 1, 2, 32'hdeadbeef, 6'h01},
    '{32'h900, 32'hdeadbeef, 1, 2, 32'hdeadbeef, 6'h00},
    '{32'h904, 32'hdeadbeef, 1, 2, 32'hdeadbeef, 6'h00}};
  logic [3:0]  cyc_act[3] = '{4'h1, 4'h4, 4'h8};
  logic [5:0]  cyc_exp[3] = '{6'h10, 6'h20, 6'h01};
  logic [3:0]  hits[4] = '{4'h0, 4'h1, 4'h8, 4'h4};
  logic [5:0]  lnk_exp[4] = '{6'h00, 6'h00, 6'h20, 6'h20};

  watch_cycle_value_compare #(.CYC_PRESENT(1))
    watch_cycle_value_compare_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .commit_valid(commit_valid),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_size(acc_size),
    .acc_data(acc_data), .acc_pc(acc_pc), .addr_hit(addr_hit),
    .address_mask_nonzero(mask_nz), .watch_event(watch_event),
    .trace_req(trace_req), .trace_pc(trace_pc),
    .comparator_match_out(cmo));
  core_model core_model_inst (
    .pclk(pclk), .commit_valid(commit_valid), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_size(acc_size), .acc_data(acc_data),
    .acc_pc(acc_pc), .addr_hit(addr_hit));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, y);
    tests_run++;
    if (y !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, y);
    end
  endtask
  function automatic logic [31:0] outs();
    return {26'h0, watch_event, trace_req, cmo};
  endfunction
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(50 * 4000);
    bad_count++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, 12'h020, rows[i].cmp);
      apb(1'b1, 12'h028, rows[i].cfg);
      core_model_inst.step(0, 1, rows[i].w, rows[i].s, rows[i].d, 0, 0);
      #1 chk("value outputs", 32'(rows[i].o), outs());
    end
    // Counter held still so the compare hits on a known commit
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h00000055);
    apb(1'b1, 12'h020, 32'h00000055);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h028, 32'h80 | 32'(cyc_act[k]));
      core_model_inst.step(1, 0, 0, 0, 0, 32'h1000 + k, 0);
      #1 chk("cycle outputs", 32'(cyc_exp[k]), outs());
    end
    chk("trace pc", 32'h1000, trace_pc);
    apb(1'b1, 12'h004, 32'h00000056);
    core_model_inst.step(1, 0, 0, 0, 0, 32'h2000, 0);
    #1 chk("cycle miss", 32'h0, outs());
    apb(1'b1, 12'h028, 32'h0);
    apb(1'b1, 12'h030, 32'h00000056);
    apb(1'b1, 12'h038, 32'h00000084);
    core_model_inst.step(1, 0, 0, 0, 0, 32'h3000, 0);
    #1 chk("cycle on comp1", 32'h0, outs());
    apb(1'b0, 12'h000, 32'h0);
    chk("counter absent", 32'h0, r & 32'h02000000);
    apb(1'b1, 12'h048, 32'h00000100);
    apb(1'b0, 12'h048, 32'h0);
    chk("value select 2", 32'h0, r & 32'h100);
    apb(1'b1, 12'h044, 32'h00000003);
    #1 chk("mask flag", 32'h4, 32'(mask_nz));
    apb(1'b1, 12'h030, 32'h77777777);
    apb(1'b1, 12'h038, 32'h00032107);
    apb(1'b0, 12'h038, 32'h0);
    chk("value select 1", 32'h100, r & 32'h100);
    for (int k = 0; k < 4; k++) begin
      core_model_inst.step(0, 1, 0, 0, 32'h77, 0, hits[k]);
      #1 chk("linked outputs", 32'(lnk_exp[k]), outs());
    end
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped data", 32'h0, r);
    chk("unmapped error", 32'h1, 32'(e));
    // Load, then let run: the read setup sees one tick past the load
    apb(1'b1, 12'h004, 32'h00000100);
    apb(1'b1, 12'h000, 32'h00000001);
    apb(1'b0, 12'h004, 32'h0);
    chk("counter run", 32'h101, r);
    // Reset in mid-run must clear the linked setup
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 32'h0, outs());
    presetn <= 1'b1;
    apb(1'b0, 12'h038, 32'h0);
    chk("reset config", 32'h0, r & 32'hfffffdff);
    chk("reset mask", 32'h0, 32'(mask_nz));
    core_model_inst.step(0, 1, 0, 0, 32'h77, 0, 4'h8);
    #1 chk("after reset", 32'h0, outs());
    wrap_up();
  end
endmodule // testbench
